// ### bench/dbt_core_model.sv
// core side model: background firmware entry and the two tag pins
`timescale 1ns/1ns
module dbt_core_model (
  input wire logic clock, // core bus clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic break_bdm_q, // break into background mode
  input wire logic [1:0] tag_req, // bench asks for a tag pin level
  output logic bdm_active, // firmware running
  output logic external_tag_low_pin, // tag pin
  output logic external_tag_high_pin // tag pin
);
  logic [3:0] stay_q;
  // firmware stays a while, so a repeated match lands inside it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      stay_q <= 4'h0;
    end else if (break_bdm_q) begin
      stay_q <= 4'h8;
    end else if (stay_q != 4'h0) begin
      stay_q <= stay_q - 4'h1;
    end
  end
  assign bdm_active = stay_q != 4'h0;
  // pins move off the clock edge, as a real pad would
  assign #3 external_tag_low_pin = tag_req[0];
  assign #3 external_tag_high_pin = tag_req[1];
endmodule

// ### bench/debug_trigger_breakpoint_logic_tb.sv
// self-checking bench for the debug trigger and breakpoint logic
`timescale 1ns/1ns
module debug_trigger_breakpoint_logic_tb;
  import dbt_pkg::*;
  logic clock = 1'b0;
  logic nrst, arm_set, secure, bdm_active, single_step_command_active;
  logic bdm_break_req, external_tag_low_pin, external_tag_high_pin;
  logic break_bdm_q, break_swi_q, break_ext_q;
  logic [1:0] tag_req;
  logic [5:0] trace_rd_idx;
  logic [31:0] trace_rd_data_q;
  logic [15:0] a_val, b_val;
  logic [15:0] w [70];
  dbt_bus_t bus;
  dbt_cmp_cfg_t cfg_a, cfg_b, cfg_c;
  dbt_ctrl_t ctrl, c;
  dbt_status_t status_q;
  int checks = 0;
  int mismatches = 0;

  always #2 clock = ~clock;

  dbt_trigger_logic DUT (.clock(clock), .nrst(nrst), .bus(bus),
    .cfg_a(cfg_a), .cfg_b(cfg_b), .cfg_c(cfg_c), .ctrl(ctrl),
    .arm_set(arm_set), .secure(secure), .bdm_active(bdm_active),
    .single_step_command_active(single_step_command_active),
    .bdm_break_req(bdm_break_req),
    .external_tag_low_pin(external_tag_low_pin),
    .external_tag_high_pin(external_tag_high_pin),
    .trace_rd_idx(trace_rd_idx), .status_q(status_q),
    .break_bdm_q(break_bdm_q), .break_swi_q(break_swi_q),
    .break_ext_q(break_ext_q), .trace_rd_data_q(trace_rd_data_q));

  dbt_core_model core (.clock(clock), .nrst(nrst),
    .break_bdm_q(break_bdm_q), .tag_req(tag_req),
    .bdm_active(bdm_active), .external_tag_low_pin(external_tag_low_pin),
    .external_tag_high_pin(external_tag_high_pin));

  function automatic dbt_bus_t bw(logic [15:0] a, logic [15:0] d,
                                  logic cf, logic xv);
    dbt_bus_t b;
    b = '0;
    b.addr = a;
    b.data = d;
    b.rw = 1'b1;
    b.cof = cf;
    b.exec_valid = xv;
    b.exec_addr = a;
    return b;
  endfunction

  function automatic dbt_ctrl_t trc(logic [3:0] m, logic bg);
    dbt_ctrl_t t;
    t = '0;
    t.trace_debug_enable = 1'b1;
    t.trig_mode = m;
    t.begin_sel = bg;
    return t;
  endfunction

  function automatic dbt_ctrl_t leg(logic sel, logic tag);
    dbt_ctrl_t t;
    t = '0;
    t.legacy_breakpoint_enable = 1'b1;
    t.bdm_select = sel;
    t.legacy_tag_ab = tag;
    return t;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic drv(input dbt_bus_t b);
    @(posedge clock);
    bus <= b;
  endtask

  task automatic idle(input int n);
    // let the last driven word be sampled first, then go quiet
    if (n > 0) @(posedge clock);
    bus <= bw(16'hffff, 16'h0000, 1'b0, 1'b0);
    if (n > 1) repeat (n - 1) @(posedge clock);
  endtask

  task automatic arm(input dbt_ctrl_t t, input logic s, input logic e);
    @(posedge clock);
    ctrl <= t;
    secure <= s;
    arm_set <= 1'b1;
    @(posedge clock);
    arm_set <= 1'b0;
    #1;
    chk(status_q.activate === e, "arm");
    if (e) chk({status_q.flag_a, status_q.flag_b, status_q.flag_c,
      status_q.count} === '0, "arm clears");
  endtask

  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    @(posedge clock);
    trace_rd_idx <= i;
    @(posedge clock);
    #1;
    chk(trace_rd_data_q === e, "trace word");
  endtask

  task automatic wait_ext();
    int n;
    for (n = 0; n < 8 && break_ext_q !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (break_ext_q !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t no break from tag pin", $time);
      finish_test();
    end
  endtask

  initial begin
    void'($urandom(72562));
    nrst = 1'b0;
    arm_set = 1'b0;
    secure = 1'b0;
    single_step_command_active = 1'b0;
    bdm_break_req = 1'b0;
    tag_req = 2'h0;
    trace_rd_idx = 6'h00;
    ctrl = '0;
    bus = bw(16'hffff, 16'h0000, 1'b0, 1'b0);
    // top bit clear keeps flow targets (top bit set) from matching
    a_val = 16'($urandom) & 16'h7ffe;
    b_val = a_val | 16'h0001;
    cfg_a = '{ext: 6'h00, value: a_val, rw_en: 1'b0, rw_lvl: 1'b0};
    cfg_b = '{ext: 6'h00, value: b_val, rw_en: 1'b0, rw_lvl: 1'b0};
    cfg_c = '{ext: 6'h00, value: a_val ^ 16'h4000, rw_en: 1'b0,
              rw_lvl: 1'b0};
    for (int i = 0; i < 70; i++) w[i] = 16'($urandom) | 16'h8000;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    #1;
    chk(status_q === '0 && break_bdm_q === 1'b0, "reset state");
    $display("test reset done");

    arm(trc(DBT_MODE_A_ONLY, 1'b0), 1'b0, 1'b1);
    drv(bw(16'h8123, 16'h0000, 1'b1, 1'b0));
    drv(bw(b_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.activate === 1'b1, "a only took b");
    drv(bw(a_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.flag_a === 1'b1 && status_q.activate === 1'b0
      && status_q.triggered === 1'b1
      && status_q.count === DBT_CNT_ONE, "a only trigger");
    for (int k = 0; k < 2; k++) begin
      c = trc(DBT_MODE_A_OR_B, 1'b0);
      c.break_on_trigger = 1'b1;
      arm(c, 1'b0, 1'b1);
      drv(bw(k ? b_val : a_val, 16'h0000, 1'b0, 1'b0));
      idle(1);
      #1;
      chk(status_q.flag_a === !k && status_q.flag_b === k[0]
        && status_q.activate === 1'b0, "a or b");
      chk(break_swi_q === 1'b1, "trace break");
    end
    $display("test single triggers done");

    arm(trc(DBT_MODE_A_THEN_B, 1'b0), 1'b0, 1'b1);
    drv(bw(b_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.flag_b === 1'b0 && status_q.activate === 1'b1,
      "b before a");
    drv(bw(a_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.flag_a === 1'b1 && status_q.activate === 1'b1,
      "a step");
    drv(bw(b_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.flag_b === 1'b1 && status_q.activate === 1'b0,
      "a then b");
    $display("test sequence done");

    // a flow change before the trigger must not be kept
    arm(trc(DBT_MODE_A_ONLY, 1'b1), 1'b0, 1'b1);
    drv(bw(16'h8001, 16'h0000, 1'b1, 1'b0));
    drv(bw(a_val, 16'h0000, 1'b0, 1'b0));
    for (int i = 0; i < 70; i++) drv(bw(w[i], 16'h0000, 1'b1, 1'b0));
    idle(1);
    #1;
    chk(status_q.count === DBT_CNT_FULL, "begin fill");
    chk(status_q.activate === 1'b0, "begin stop");
    rd(6'h00, {w[0], 16'h0000});
    rd(6'h3f, {w[63], 16'h0000});
    $display("test begin trigger done");

    arm(trc(DBT_MODE_A_ONLY, 1'b0), 1'b0, 1'b1);
    for (int i = 0; i < 70; i++) drv(bw(w[i], 16'h0000, 1'b1, 1'b0));
    drv(bw(a_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.count === DBT_CNT_FULL
      && status_q.activate === 1'b0, "end trigger");
    rd(6'h00, {w[6], 16'h0000});
    rd(6'h3f, {w[69], 16'h0000});
    $display("test end trigger done");

    c = trc(DBT_MODE_EV_B, 1'b0);
    c.tag_trigger_select = 1'b1;
    arm(c, 1'b0, 1'b1);
    drv(bw(b_val, w[3], 1'b0, 1'b0));
    idle(1);
    #1;
    chk(status_q.flag_b === 1'b1 && status_q.count === DBT_CNT_ONE
      && status_q.activate === 1'b1, "event b");
    rd(6'h00, {16'h0000, w[3]});
    c.legacy_breakpoint_enable = 1'b1;
    @(posedge clock);
    ctrl <= c;
    repeat (2) @(posedge clock);
    #1;
    chk(status_q.activate === 1'b0, "legacy override");
    arm(c, 1'b0, 1'b0);
    arm(trc(DBT_MODE_A_ONLY, 1'b0), 1'b1, 1'b0);
    $display("test arming limits done");

    @(posedge clock);
    secure <= 1'b0;
    ctrl <= leg(1'b0, 1'b0);
    drv(bw(a_val, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(break_swi_q === 1'b1 && break_bdm_q === 1'b0, "swi");
    c = leg(1'b0, 1'b0);
    c.comp_c_break_enable = 1'b1;
    @(posedge clock);
    ctrl <= c;
    drv(bw(a_val ^ 16'h4000, 16'h0000, 1'b0, 1'b0));
    idle(1);
    #1;
    chk(break_swi_q === 1'b1, "comparator c break");
    @(posedge clock);
    ctrl <= leg(1'b1, 1'b0);
    drv(bw(a_val, 16'h0000, 1'b0, 1'b0));
    @(posedge clock);
    #1;
    chk(break_bdm_q === 1'b1 && break_swi_q === 1'b0, "bdm");
    repeat (4) @(posedge clock);
    #1;
    chk(bdm_active === 1'b1 && break_bdm_q === 1'b0
      && break_swi_q === 1'b0, "no break in firmware");
    idle(12);
    $display("test legacy breaks done");

    @(posedge clock);
    ctrl <= leg(1'b0, 1'b0);
    bus <= bw(a_val, 16'h0000, 1'b0, 1'b0);
    bdm_break_req <= 1'b1;
    @(posedge clock);
    bdm_break_req <= 1'b0;
    idle(0);
    #1;
    chk(break_bdm_q === 1'b1 && break_ext_q === 1'b1
      && break_swi_q === 1'b0, "external first");
    idle(12);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      tag_req <= 2'h1 << k;
      wait_ext();
      @(posedge clock);
      tag_req <= 2'h0;
      idle(12);
    end
    $display("test external breaks done");

    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      ctrl <= leg(1'b1, 1'b1);
      single_step_command_active <= s[0];
      bus <= bw(a_val, 16'h0000, 1'b0, 1'b1);
      idle(1);
      #1;
      chk(break_bdm_q === !s, "tag during step");
      @(posedge clock);
      single_step_command_active <= 1'b0;
      idle(12);
    end
    $display("test step blocking done");
    finish_test();
  end
endmodule

// ### pkg/dbt_pkg.sv
// constants and carrier types for the debug trigger and breakpoint logic
package dbt_pkg;
  localparam int unsigned DBT_DEPTH = 64;
  localparam int unsigned DBT_PTR_W = 6;
  localparam int unsigned DBT_CNT_W = 7;
  localparam int unsigned DBT_AW = 16;
  localparam int unsigned DBT_DW = 16;
  localparam int unsigned DBT_XW = 6;
  localparam int unsigned DBT_EW = DBT_AW + DBT_DW;
  localparam logic [DBT_CNT_W-1:0] DBT_CNT_FULL = 7'h40;
  localparam logic [DBT_CNT_W-1:0] DBT_CNT_LAST = 7'h3f;
  localparam logic [DBT_CNT_W-1:0] DBT_CNT_ONE = 7'h01;
  localparam logic [DBT_PTR_W-1:0] DBT_PTR_ONE = 6'h01;
  localparam logic [DBT_DW-1:0] DBT_ZERO_WORD = 16'h0000;
  // page select: only the low bit counts, 10/11 read as 00/01
  localparam int unsigned DBT_PAGE_EXT_BIT = 0;
  // trigger mode field coding
  localparam logic [3:0] DBT_MODE_A_ONLY = 4'h0;
  localparam logic [3:0] DBT_MODE_A_OR_B = 4'h1;
  localparam logic [3:0] DBT_MODE_A_THEN_B = 4'h2;
  localparam logic [3:0] DBT_MODE_EV_B = 4'h3;
  localparam logic [3:0] DBT_MODE_A_AND_B = 4'h5;

  typedef struct packed {
    logic [DBT_XW-1:0] ext;   // extended compare bits
    logic [DBT_AW-1:0] value; // high and low compare bytes
    logic rw_en;
    logic rw_lvl;
  } dbt_cmp_cfg_t;

  typedef struct packed {
    logic [DBT_AW-1:0] addr;      // core address bus
    logic [21:14] xaddr;          // expanded address bits
    logic [DBT_DW-1:0] data;      // core data bus
    logic rw;                     // 1 read, 0 write
    logic pfetch;                 // program fetch cycle
    logic free;                   // free cycle
    logic cof;                    // change of flow, addr is the target
    logic exec_valid;             // opcode about to execute
    logic [DBT_AW-1:0] exec_addr; // its address from opcode tracking
  } dbt_bus_t;

  typedef struct packed {
    logic trace_debug_enable;
    logic legacy_breakpoint_enable;
    logic [1:0] page_select_field;
    logic tag_trigger_select;
    logic [3:0] trig_mode;
    logic begin_sel;
    logic detail_capture;
    logic break_on_trigger;
    logic bdm_select;      // comparator breaks go to background unit, else swi
    logic legacy_tag_ab;
    logic legacy_full;
    logic comp_c_break_enable;
    logic comp_c_tag_select;
    logic comp_c_rw_enable;
    logic comp_c_rw_level;
  } dbt_ctrl_t;

  typedef struct packed {
    logic activate;
    logic flag_a;
    logic flag_b;
    logic flag_c;
    logic triggered;
    logic [DBT_CNT_W-1:0] count;
  } dbt_status_t;
endpackage

// ### verilog/dbt_cmp.sv
// one address or data comparator with page and read/write qualification
`timescale 1ns/1ns
module dbt_cmp (
  input dbt_pkg::dbt_cmp_cfg_t cfg, // stored compare value
  input wire logic [dbt_pkg::DBT_AW-1:0] addr, // address to compare
  input wire logic [21:14] xaddr, // expanded address bits
  input wire logic [dbt_pkg::DBT_DW-1:0] data, // data bus
  input wire logic rw, // bus direction
  input wire logic page_ext, // match the upper address bits too
  input wire logic use_data, // compare data instead of address
  input wire logic rw_check, // qualify by direction
  input wire logic rw_lvl, // direction wanted
  output logic match // combinational hit
);
  import dbt_pkg::*;
  logic [DBT_AW-1:0] probe;
  logic ext_ok;

  always_comb begin
    probe = addr;
    if (use_data) begin
      probe = data;
    end else if (page_ext) begin
      probe = {xaddr[15:14], addr[13:0]};
    end
  end

  assign ext_ok = ~page_ext | use_data | (cfg.ext == xaddr[21:16]);
  assign match = (probe == cfg.value) & ext_ok & (~rw_check | (rw == rw_lvl));
endmodule

// ### verilog/dbt_trigger_logic.sv
// comparator, trigger, trace buffer and breakpoint arbitration logic
`timescale 1ns/1ns
// How it works
// - no breakpoints while background firmware runs
// - single step blocks tagged entry to background
// - background requests win over software interrupt
// - background unit and tag pins beat comparators
// - legacy tagged break repeats on return to instruction
// - legacy mode adds comparator C breakpoint
// - comparators A and B match address bus
// - full modes: comparator B matches data bus
// - trace mode page select 01 compares extended bits
// - tagged C break hides same-address A/B trigger
// - tag select ignores A/B direction enables
// - A and B trace mode: A direction bits govern both
// - tag select waits for execution, else forced
// - controller decides storing and break requests
// - begin trigger stores 64 then stops
// - end trigger stores until trigger, wrapping
// - activate clears on trigger or fill
// - arming clears flags, matches set them
// - store flow, event data or detail cycles
// - A only and A or B triggering
// - A then B evaluates B after A
// - event-only B is begin type, untagged
// - legacy enable overrides trace enable
// - secured part cannot use trace mode
module dbt_trigger_logic (
  input wire logic clock, // core bus clock
  input wire logic nrst, // synchronous reset, active low
  input dbt_pkg::dbt_bus_t bus, // core buses
  input dbt_pkg::dbt_cmp_cfg_t cfg_a, // comparator A setup
  input dbt_pkg::dbt_cmp_cfg_t cfg_b, // comparator B setup
  input dbt_pkg::dbt_cmp_cfg_t cfg_c, // comparator C setup
  input dbt_pkg::dbt_ctrl_t ctrl, // control bits
  input wire logic arm_set, // pulse: software sets activate
  input wire logic secure, // part is secured
  input wire logic bdm_active, // cpu runs background firmware
  input wire logic single_step_command_active, // step command running
  input wire logic bdm_break_req, // break from background unit
  input wire logic external_tag_low_pin, // tag pin, asynchronous
  input wire logic external_tag_high_pin, // tag pin, asynchronous
  input wire logic [dbt_pkg::DBT_PTR_W-1:0] trace_rd_idx, // 0 is oldest
  output dbt_pkg::dbt_status_t status_q, // status bits
  output logic break_bdm_q, // pulse: enter background mode
  output logic break_swi_q, // pulse: software interrupt
  output logic break_ext_q, // pulse: break came from background unit or a tag pin
  output logic [dbt_pkg::DBT_EW-1:0] trace_rd_data_q // trace word
);
  import dbt_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CAPTURE} dbt_state_t;

  dbt_state_t state_q;
  dbt_state_t state_d;
  logic [DBT_EW-1:0] trace_mem [DBT_DEPTH];
  logic [DBT_PTR_W-1:0] wptr_q;
  logic [1:0] tag_lo_sync_q;
  logic [1:0] tag_hi_sync_q;
  logic a_seen_q;
  logic dbg_on, full_mode, ev_only, tagging, begin_eff, tag_ab;
  logic page_ext, hit_a, hit_b, hit_c, valid_ab, valid_c;
  logic ma, mb, mc, trig, set_a, set_b, wr, store_want;
  logic legacy_brk, trace_brk, cmp_brk, cmp_tagged, cmp_ok, ext_ok;
  logic [DBT_AW-1:0] addr_ab, addr_c;
  logic [DBT_EW-1:0] entry;
  logic [DBT_PTR_W-1:0] oldest;

  // legacy mode wins and a secured part stays out of trace mode
  assign dbg_on = ctrl.trace_debug_enable & ~ctrl.legacy_breakpoint_enable
    & ~secure;
  assign full_mode = dbg_on & (ctrl.trig_mode == DBT_MODE_A_AND_B);
  assign ev_only = (ctrl.trig_mode == DBT_MODE_EV_B)
    & ~ctrl.detail_capture;
  assign tagging = ctrl.tag_trigger_select & ~ev_only;
  assign begin_eff = ctrl.begin_sel | ev_only;
  assign tag_ab = ctrl.legacy_breakpoint_enable ? ctrl.legacy_tag_ab
    : tagging;
  assign page_ext = dbg_on & ctrl.page_select_field[DBT_PAGE_EXT_BIT];

  // tagged compares look at the opcode about to execute
  assign addr_ab = tag_ab ? bus.exec_addr : bus.addr;
  assign valid_ab = ~tag_ab | bus.exec_valid;
  assign addr_c = ctrl.comp_c_tag_select ? bus.exec_addr : bus.addr;
  assign valid_c = ~ctrl.comp_c_tag_select | bus.exec_valid;

  dbt_cmp u_cmp_a (
    .cfg(cfg_a),
    .addr(addr_ab),
    .xaddr(bus.xaddr),
    .data(bus.data),
    .rw(bus.rw),
    .page_ext(page_ext),
    .use_data(1'b0),
    .rw_check(cfg_a.rw_en & ~tag_ab),
    .rw_lvl(cfg_a.rw_lvl),
    .match(hit_a)
  );

  dbt_cmp u_cmp_b (
    .cfg(cfg_b),
    .addr(addr_ab),
    .xaddr(bus.xaddr),
    .data(bus.data),
    .rw(bus.rw),
    .page_ext(page_ext),
    .use_data(full_mode | (ctrl.legacy_breakpoint_enable
      & ctrl.legacy_full)),
    // A and B trace mode borrows A's direction bits for B; legacy full keeps B's own
    .rw_check(~tag_ab & (full_mode ? cfg_a.rw_en
      : cfg_b.rw_en)),
    .rw_lvl(full_mode ? cfg_a.rw_lvl : cfg_b.rw_lvl),
    .match(hit_b)
  );

  dbt_cmp u_cmp_c (
    .cfg(cfg_c),
    .addr(addr_c),
    .xaddr(bus.xaddr),
    .data(bus.data),
    .rw(bus.rw),
    .page_ext(page_ext),
    .use_data(1'b0),
    .rw_check(ctrl.comp_c_rw_enable & ~ctrl.comp_c_tag_select),
    .rw_lvl(ctrl.comp_c_rw_level),
    .match(hit_c)
  );

  assign mc = hit_c & valid_c;
  // a tagged C break at the same opcode hides the A/B trigger
  assign ma = hit_a & valid_ab & ~(mc & tag_ab & ctrl.comp_c_tag_select
    & ctrl.comp_c_break_enable);
  assign mb = hit_b & valid_ab & ~(mc & tag_ab & ctrl.comp_c_tag_select
    & ctrl.comp_c_break_enable);

  // trigger decode per mode
  always_comb begin
    trig = 1'b0;
    set_a = 1'b0;
    set_b = 1'b0;
    unique case (ctrl.trig_mode)
      DBT_MODE_A_ONLY: begin
        trig = ma;
        set_a = ma;
      end
      DBT_MODE_A_OR_B: begin
        trig = ma | mb;
        set_a = ma;
        set_b = mb;
      end
      DBT_MODE_A_THEN_B: begin
        trig = mb & a_seen_q;
        set_a = ma;
        set_b = mb & a_seen_q;
      end
      DBT_MODE_EV_B: begin
        trig = mb;
        set_b = mb;
      end
      DBT_MODE_A_AND_B: begin
        trig = tagging ? ma : (ma & mb);
        set_a = trig;
        set_b = trig;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
  end

  // what gets stored and when
  always_comb begin
    store_want = bus.cof;
    entry = {bus.addr, DBT_ZERO_WORD};
    if (ctrl.detail_capture) begin
      store_want = ~bus.pfetch & ~bus.free;
      entry = {bus.addr, bus.data};
    end else if (ev_only) begin
      store_want = mb;
      entry = {DBT_ZERO_WORD, bus.data};
    end
  end

  assign wr = store_want & ((state_q == ST_CAPTURE)
    | ((state_q == ST_ARMED) & (~begin_eff | (ev_only & trig))));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (arm_set & dbg_on) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (trig) begin
          state_d = begin_eff ? ST_CAPTURE : ST_IDLE;
        end
      end
      ST_CAPTURE: begin
        if (wr & (status_q.count == DBT_CNT_LAST)) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (~dbg_on) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // status and write pointer in one process: status_q has a single driver
  always_ff @(posedge clock) begin
    if (!nrst) begin
      status_q <= '0;
      wptr_q <= '0;
      a_seen_q <= 1'b0;
    end else begin
      status_q.activate <= (state_d != ST_IDLE);
      if (state_q == ST_IDLE & arm_set & dbg_on) begin
        // a match in the arming cycle does not count, only armed ones do
        status_q.flag_a <= 1'b0;
        status_q.flag_b <= 1'b0;
        status_q.flag_c <= 1'b0;
        status_q.triggered <= 1'b0;
        status_q.count <= '0;
        wptr_q <= '0;
        a_seen_q <= 1'b0;
      end else begin
        if (state_q == ST_ARMED) begin
          status_q.flag_a <= status_q.flag_a | set_a;
          status_q.flag_b <= status_q.flag_b | set_b;
          status_q.flag_c <= status_q.flag_c | mc;
          status_q.triggered <= status_q.triggered | trig;
          a_seen_q <= a_seen_q | ma;
        end
        // end trigger overwrites the oldest word
        if (wr) begin
          wptr_q <= wptr_q + DBT_PTR_ONE;
          if (status_q.count != DBT_CNT_FULL) begin
            status_q.count <= status_q.count + DBT_CNT_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (wr) begin
      trace_mem[wptr_q] <= entry;
    end
  end

  assign oldest = (status_q.count == DBT_CNT_FULL) ? wptr_q : '0;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      trace_rd_data_q <= '0;
    end else begin
      trace_rd_data_q <= trace_mem[oldest + trace_rd_idx];
    end
  end

  // tag pins come from outside; plain two-stage synchronisers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tag_lo_sync_q <= '0;
      tag_hi_sync_q <= '0;
    end else begin
      tag_lo_sync_q <= {tag_lo_sync_q[0], external_tag_low_pin};
      tag_hi_sync_q <= {tag_hi_sync_q[0], external_tag_high_pin};
    end
  end

  // no one-shot latch: a re-executed tagged opcode hits again
  assign legacy_brk = ctrl.legacy_breakpoint_enable & (
    (ctrl.legacy_full ? (tag_ab ? ma : (ma & mb)) : (ma | mb))
    | (ctrl.comp_c_break_enable & mc));
  assign trace_brk = dbg_on & (state_q == ST_ARMED) & trig
    & ctrl.break_on_trigger;
  assign cmp_brk = legacy_brk | trace_brk;
  assign cmp_tagged = ctrl.legacy_breakpoint_enable
    ? ((ctrl.comp_c_break_enable & mc) ? ctrl.comp_c_tag_select : tag_ab)
    : tagging;
  assign ext_ok = bdm_break_req | ((tag_lo_sync_q[1] | tag_hi_sync_q[1])
    & ~single_step_command_active);
  assign cmp_ok = cmp_brk & ~(cmp_tagged & ctrl.bdm_select
    & single_step_command_active);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      break_bdm_q <= 1'b0;
      break_swi_q <= 1'b0;
      break_ext_q <= 1'b0;
    end else if (bdm_active) begin
      break_bdm_q <= 1'b0;
      break_swi_q <= 1'b0;
      break_ext_q <= 1'b0;
    end else begin
      break_ext_q <= ext_ok;
      break_bdm_q <= ext_ok | (cmp_ok & ctrl.bdm_select);
      break_swi_q <= cmp_ok & ~ctrl.bdm_select & ~ext_ok;
    end
  end

  sequence s_arm;
    state_q == ST_IDLE && arm_set && dbg_on;
  endsequence

  a_bdm_quiet: assert property (@(posedge clock) disable iff (!nrst)
    $past(bdm_active) |-> !break_bdm_q && !break_swi_q)
    else $error("break raised while background firmware active");

  a_bdm_over_swi: assert property (@(posedge clock) disable iff (!nrst)
    !(break_bdm_q && break_swi_q))
    else $error("background and swi break together");

  a_ext_first: assert property (@(posedge clock) disable iff (!nrst)
    break_ext_q |-> break_bdm_q && !break_swi_q)
    else $error("external break lost priority");

  a_step_no_tag: assert property (@(posedge clock) disable iff (!nrst)
    ($past(single_step_command_active) && !$past(bdm_break_req)
      && $past(cmp_tagged)) |-> !break_bdm_q)
    else $error("tagged entry during single step");

  a_arm_clears: assert property (@(posedge clock) disable iff (!nrst)
    s_arm |=> !status_q.flag_a && !status_q.flag_b && status_q.count == '0)
    else $error("arming left flag or count");

  a_begin_stops: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == ST_CAPTURE && wr && status_q.count == DBT_CNT_LAST)
      |=> !status_q.activate && status_q.count == DBT_CNT_FULL)
    else $error("begin capture did not stop at full");

  a_end_disarm: assert property (@(posedge clock) disable iff (!nrst)
    (state_q == ST_ARMED && trig && !begin_eff && dbg_on)
      |=> !status_q.activate && !wr)
    else $error("end trigger did not clear activate");

  a_secure_off: assert property (@(posedge clock) disable iff (!nrst)
    (secure || ctrl.legacy_breakpoint_enable) [*2] |-> state_q == ST_IDLE)
    else $error("trace mode ran while locked out");

  a_then_b: assert property (@(posedge clock) disable iff (!nrst)
    (ctrl.trig_mode == DBT_MODE_A_THEN_B && !a_seen_q) |-> !trig)
    else $error("A then B fired before A");
endmodule
